// ---- hdl/chan2_drive_defines.svh ----
// register offsets, field positions, reset values and timing figures of the bank
// assumes inclusion by bare name from the two modules, not from the package
`ifndef CHAN2_DRIVE_DEFINES_SVH
`define CHAN2_DRIVE_DEFINES_SVH

`define ADDR_CHANNEL2_SETTINGS   8'h05
`define ADDR_DRIVE_SENSE_SELECT  8'h06
`define RST_CHANNEL2_SETTINGS    8'h00
`define RST_DRIVE_SENSE_SELECT   8'h00

`define CH2_PD_BIT        7
`define CH2_GAIN_MSB      6
`define CH2_GAIN_LSB      4
`define CH2_MUX_MSB       3
`define CH2_MUX_LSB       0
`define DRV_CHOP_MSB      7
`define DRV_CHOP_LSB      6
`define DRV_BUF_BIT       5
`define DRV_LOFF_BIT      4
`define DRV_CH2N_BIT      3
`define DRV_CH2P_BIT      2
`define DRV_CH1N_BIT      1
`define DRV_CH1P_BIT      0

// modulator divide ratios, as divider counter terminal values (ratio - 1)
`define MOD_DIV4_LAST     4'h3
`define MOD_DIV16_LAST    4'hF
// chop divide ratios of the modulator rate, as terminal values
`define CHOP_DIV16_LAST   4'hF
`define CHOP_DIV2_LAST    4'h1
`define CHOP_DIV4_LAST    4'h3

`endif

// ---- hdl/chan2_drive_pkg.sv ----
// types shared by the channel-two and drive sense register bank
// assumes the defines header sits beside it
package chan2_drive_pkg;

    // amplifier gain codes of channel two
    typedef enum logic [2:0] {
        GAIN_6  = 3'h0,
        GAIN_1  = 3'h1,
        GAIN_2  = 3'h2,
        GAIN_3  = 3'h3,
        GAIN_4  = 3'h4,
        GAIN_8  = 3'h5,
        GAIN_12 = 3'h6,
        GAIN_RSV = 3'h7
    } gain_code_e;

    // input selections of channel two
    typedef enum logic [3:0] {
        IN_NORMAL       = 4'h0,
        IN_SHORTED      = 4'h1,
        IN_DRIVE_MEAS   = 4'h2,
        IN_HALF_SUPPLY  = 4'h3,
        IN_TEMP         = 4'h4,
        IN_TEST         = 4'h5,
        IN_POS_TO_DRIVE = 4'h6,
        IN_NEG_TO_DRIVE = 4'h7,
        IN_BOTH_TO_DRIVE = 4'h8,
        IN_THIRD_PAIR   = 4'h9
    } input_sel_e;

    // chop frequency selections
    typedef enum logic [1:0] {
        CHOP_DIV16 = 2'h0,
        CHOP_RSV   = 2'h1,
        CHOP_DIV2  = 2'h2,
        CHOP_DIV4  = 2'h3
    } chop_sel_e;

    // divider states
    typedef enum logic [0:0] {
        DIV_IDLE = 1'b0,
        DIV_RUN  = 1'b1
    } div_state_e;

endpackage

// ---- hdl/chop_divider.sv ----
// two-stage divider: input clock to modulator rate, modulator rate to chop rate
// assumes one system clock; outputs are one-cycle enable pulses
`timescale 1ns/1ps
`include "chan2_drive_defines.svh"

module chop_divider
    import chan2_drive_pkg::*;
(
    input  wire logic       i_clk_sys,
    input  wire logic       i_rst,
    input  wire logic       i_run,
    input  wire logic       i_mod_div16,
    input  wire logic [1:0] i_chop_sel,
    output logic            o_mod_tick,
    output logic            o_chop_tick
);

    typedef struct packed {
        div_state_e state;
        logic [3:0] mod_cnt;
        logic [3:0] chop_cnt;
        logic       mod_tick;
        logic       chop_tick;
    } div_s;

    div_s div_r;
    div_s div_nxt;

    // =====================================================================
    // next state
    // =====================================================================
    always_comb begin
        logic [3:0] mod_last;
        logic [3:0] chop_last;
        mod_last  = i_mod_div16 ? `MOD_DIV16_LAST : `MOD_DIV4_LAST;
        chop_last = `CHOP_DIV16_LAST;
        case (chop_sel_e'(i_chop_sel))
            CHOP_DIV2: chop_last = `CHOP_DIV2_LAST;
            CHOP_DIV4: chop_last = `CHOP_DIV4_LAST;
            default:   chop_last = `CHOP_DIV16_LAST; // reserved code falls back
        endcase
        div_nxt           = div_r;
        div_nxt.mod_tick  = 1'b0;
        div_nxt.chop_tick = 1'b0;
        case (div_r.state)
            DIV_IDLE: begin
                div_nxt.mod_cnt  = 4'h0;
                div_nxt.chop_cnt = 4'h0;
                if (i_run) begin
                    div_nxt.state = DIV_RUN;
                end
            end
            DIV_RUN: begin
                if (!i_run) begin
                    div_nxt.state = DIV_IDLE;
                end else if (div_r.mod_cnt >= mod_last) begin
                    // >= so a ratio change mid-count never overruns
                    div_nxt.mod_cnt  = 4'h0;
                    div_nxt.mod_tick = 1'b1;
                    if (div_r.chop_cnt >= chop_last) begin
                        div_nxt.chop_cnt  = 4'h0;
                        div_nxt.chop_tick = 1'b1;
                    end else begin
                        div_nxt.chop_cnt = div_r.chop_cnt + 4'h1;
                    end
                end else begin
                    div_nxt.mod_cnt = div_r.mod_cnt + 4'h1;
                end
            end
            default: begin
                div_nxt.state = DIV_IDLE;
            end
        endcase
    end

    // state register
    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            div_r <= '0;
        end else begin
            div_r <= div_nxt;
        end
    end

    assign o_mod_tick  = div_r.mod_tick;
    assign o_chop_tick = div_r.chop_tick;

endmodule

// ---- hdl/chan2_drive_sense_regs.sv ----
// channel-two settings and drive sense selection register bank
// assumes a plain register port from the serial engine, one system clock
// Operation
// - 0x05 and 0x06, eight-bit, read/write
// - bit 7 powers channel two down
// - bits 6:4 pick channel-two gain
// - bits 3:0 pick channel-two input
// - 1001 third pair; 1010 reserved
// - bits 7:6 pick chop divide ratio
// - bit 5 powers drive buffer
// - bit 4 enables drive lead-off sensing
// - bits 3:0 feed inputs to drive
// - modulator clock is input/4 or /16
`timescale 1ns/1ps
`include "chan2_drive_defines.svh"

module chan2_drive_sense_regs
    import chan2_drive_pkg::*;
(
    input  wire logic       i_clk_sys,
    input  wire logic       i_rst,
    input  wire logic [7:0] i_addr,
    input  wire logic [7:0] i_wdata,
    input  wire logic       i_wr,
    input  wire logic       i_rd,
    output logic [7:0]      o_rdata,
    input  wire logic       i_mod_div16,
    output logic            o_ch2_power_down,
    output logic            o_ch2_active,
    output logic [2:0]      o_ch2_gain_code,
    output logic [3:0]      o_ch2_gain_value,
    output logic [3:0]      o_ch2_input_select,
    output logic            o_ch2_normal_input,
    output logic            o_ch2_inputs_shorted,
    output logic            o_drive_measurement_input,
    output logic            o_ch2_half_supply,
    output logic            o_ch2_temp_sensor,
    output logic            o_ch2_test_signal,
    output logic            o_pos_to_drive_input,
    output logic            o_neg_to_drive_input,
    output logic            o_third_pair_positive,
    output logic            o_third_pair_negative,
    output logic [1:0]      o_chop_select,
    output logic            o_mod_tick,
    output logic            o_chop_tick,
    output logic            o_drive_buffer_power,
    output logic            o_drive_leadoff_sense_en,
    output logic            o_ch2_neg_to_drive,
    output logic            o_ch2_pos_to_drive,
    output logic            o_ch1_neg_to_drive,
    output logic            o_ch1_pos_to_drive
);

    // =====================================================================
    // state
    // =====================================================================
    typedef struct packed {
        logic [7:0] channel2_settings;
        logic [7:0] drive_sense_select;
        logic [7:0] rdata;
        logic [3:0] gain_value;
        logic [9:0] route;
    } bank_s;

    bank_s bank_r;
    bank_s bank_nxt;

    // gain code to amplifier gain; the unused code reads as zero gain
    function automatic logic [3:0] gain_of(input logic [2:0] code);
        case (gain_code_e'(code))
            GAIN_6:  gain_of = 4'h6;
            GAIN_1:  gain_of = 4'h1;
            GAIN_2:  gain_of = 4'h2;
            GAIN_3:  gain_of = 4'h3;
            GAIN_4:  gain_of = 4'h4;
            GAIN_8:  gain_of = 4'h8;
            GAIN_12: gain_of = 4'hC;
            default: gain_of = 4'h0;
        endcase
    endfunction

    // input code to switch set, one switch for each of codes 0 to 7, two for codes 8 and 9:
    // {normal,short,meas,half,temp,test,pos_drv,neg_drv,third_p,third_n}
    function automatic logic [9:0] route_of(input logic [3:0] code);
        case (input_sel_e'(code))
            IN_NORMAL:        route_of = 10'h200;
            IN_SHORTED:       route_of = 10'h100;
            IN_DRIVE_MEAS:    route_of = 10'h080;
            IN_HALF_SUPPLY:   route_of = 10'h040;
            IN_TEMP:          route_of = 10'h020;
            IN_TEST:          route_of = 10'h010;
            IN_POS_TO_DRIVE:  route_of = 10'h008;
            IN_NEG_TO_DRIVE:  route_of = 10'h004;
            IN_BOTH_TO_DRIVE: route_of = 10'h00C;
            IN_THIRD_PAIR:    route_of = 10'h003;
            // reserved and undefined codes open every switch
            default:          route_of = 10'h000;
        endcase
    endfunction

    // =====================================================================
    // register access and decoding
    // =====================================================================
    always_comb begin
        bank_nxt       = bank_r;
        bank_nxt.rdata = 8'h00;
        if (i_wr) begin
            case (i_addr)
                `ADDR_CHANNEL2_SETTINGS:  bank_nxt.channel2_settings  = i_wdata;
                `ADDR_DRIVE_SENSE_SELECT: bank_nxt.drive_sense_select = i_wdata;
                default: ;
            endcase
        end
        if (i_rd) begin
            case (i_addr)
                `ADDR_CHANNEL2_SETTINGS:  bank_nxt.rdata = bank_r.channel2_settings;
                `ADDR_DRIVE_SENSE_SELECT: bank_nxt.rdata = bank_r.drive_sense_select;
                default:                  bank_nxt.rdata = 8'h00;
            endcase
        end
        // gain decode, follows the stored code one cycle later
        bank_nxt.gain_value = gain_of(
            bank_r.channel2_settings[`CH2_GAIN_MSB:`CH2_GAIN_LSB]);
        bank_nxt.route = route_of(bank_r.channel2_settings[`CH2_MUX_MSB:`CH2_MUX_LSB]);
    end

    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            bank_r                    <= '0;
            bank_r.channel2_settings  <= `RST_CHANNEL2_SETTINGS;
            bank_r.drive_sense_select <= `RST_DRIVE_SENSE_SELECT;
            bank_r.route              <= 10'h200;
            bank_r.gain_value         <= 4'h6;
        end else begin
            bank_r <= bank_nxt;
        end
    end

    // =====================================================================
    // channel-two controls
    // =====================================================================
    assign o_rdata = bank_r.rdata;
    assign o_ch2_power_down = bank_r.channel2_settings[`CH2_PD_BIT];
    assign o_ch2_active     = ~bank_r.channel2_settings[`CH2_PD_BIT];
    assign o_ch2_gain_code  = bank_r.channel2_settings[`CH2_GAIN_MSB:`CH2_GAIN_LSB];
    assign o_ch2_gain_value = bank_r.gain_value;
    assign o_ch2_input_select = bank_r.channel2_settings[`CH2_MUX_MSB:`CH2_MUX_LSB];

    // switch controls, two closed for codes 8 and 9; software is expected to short inputs on power-down
    assign o_ch2_normal_input        = bank_r.route[9];
    assign o_ch2_inputs_shorted      = bank_r.route[8];
    assign o_drive_measurement_input = bank_r.route[7];
    assign o_ch2_half_supply         = bank_r.route[6];
    assign o_ch2_temp_sensor         = bank_r.route[5];
    assign o_ch2_test_signal         = bank_r.route[4];
    assign o_pos_to_drive_input      = bank_r.route[3];
    assign o_neg_to_drive_input      = bank_r.route[2];
    assign o_third_pair_positive     = bank_r.route[1];
    assign o_third_pair_negative     = bank_r.route[0];

    // =====================================================================
    // drive sense controls
    // =====================================================================
    assign o_chop_select = bank_r.drive_sense_select[`DRV_CHOP_MSB:`DRV_CHOP_LSB];
    assign o_drive_buffer_power     = bank_r.drive_sense_select[`DRV_BUF_BIT];
    assign o_drive_leadoff_sense_en = bank_r.drive_sense_select[`DRV_LOFF_BIT];
    assign o_ch2_neg_to_drive = bank_r.drive_sense_select[`DRV_CH2N_BIT];
    assign o_ch2_pos_to_drive = bank_r.drive_sense_select[`DRV_CH2P_BIT];
    assign o_ch1_neg_to_drive = bank_r.drive_sense_select[`DRV_CH1N_BIT];
    assign o_ch1_pos_to_drive = bank_r.drive_sense_select[`DRV_CH1P_BIT];

    // chop and modulator dividers; they halt while channel two sleeps
    chop_divider u_chop_divider (
        .i_clk_sys   (i_clk_sys),
        .i_rst       (i_rst),
        .i_run       (o_ch2_active),
        .i_mod_div16 (i_mod_div16),
        .i_chop_sel  (o_chop_select),
        .o_mod_tick  (o_mod_tick),
        .o_chop_tick (o_chop_tick)
    );

endmodule

// ---- tb/chan2_drive_sense_regs_asserts.sv ----
// checker for the channel-two and drive sense register bank
// assumes it is bound to the bank and sees only its ports
`timescale 1ns/1ps

module chan2_drive_sense_regs_asserts (
    input wire logic       i_clk_sys,
    input wire logic       i_rst,
    input wire logic [7:0] i_addr,
    input wire logic [7:0] i_wdata,
    input wire logic       i_wr,
    input wire logic       i_rd,
    input wire logic [7:0] o_rdata,
    input wire logic       o_ch2_power_down,
    input wire logic [2:0] o_ch2_gain_code,
    input wire logic [3:0] o_ch2_gain_value,
    input wire logic [3:0] o_ch2_input_select,
    input wire logic       o_pos_to_drive_input,
    input wire logic       o_neg_to_drive_input,
    input wire logic       o_third_pair_positive,
    input wire logic       o_third_pair_negative,
    input wire logic [1:0] o_chop_select,
    input wire logic       o_mod_tick,
    input wire logic       o_chop_tick,
    input wire logic       o_drive_buffer_power,
    input wire logic       o_drive_leadoff_sense_en,
    input wire logic       o_ch2_neg_to_drive,
    input wire logic       o_ch2_pos_to_drive,
    input wire logic       o_ch1_neg_to_drive,
    input wire logic       o_ch1_pos_to_drive
);
    // one domain, so clock and reset are given once
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (i_rst);

    // ==========================================================
    // register writes and reads
    property p_wr_pd;
        i_wr && i_addr == 8'h05 |=> o_ch2_power_down == $past(i_wdata[7]);
    endproperty
    a_wr_pd: assert property (p_wr_pd) else $error("power-down bit not written");
    property p_gain;
        i_wr && i_addr == 8'h05 |=> o_ch2_gain_code == $past(i_wdata[6:4]);
    endproperty
    a_gain: assert property (p_gain) else $error("gain code not written");
    property p_mux;
        i_wr && i_addr == 8'h05 |=> o_ch2_input_select == $past(i_wdata[3:0]);
    endproperty
    a_mux: assert property (p_mux) else $error("input code not written");
    property p_drv;
        i_wr && i_addr == 8'h06 |=> {o_chop_select, o_drive_buffer_power, o_drive_leadoff_sense_en,
            o_ch2_neg_to_drive, o_ch2_pos_to_drive, o_ch1_neg_to_drive, o_ch1_pos_to_drive}
            == $past(i_wdata);
    endproperty
    a_drv: assert property (p_drv) else $error("drive sense fields not written");
    property p_rd;
        i_rd && i_addr == 8'h05 |=>
            o_rdata == $past({o_ch2_power_down, o_ch2_gain_code, o_ch2_input_select});
    endproperty
    a_rd: assert property (p_rd) else $error("settings readback wrong");
    property p_rdz;
        !(i_rd && (i_addr == 8'h05 || i_addr == 8'h06)) |=> o_rdata == 8'h00;
    endproperty
    a_rdz: assert property (p_rdz) else $error("read data not zero");

    // ==========================================================
    // decoded outputs, one cycle behind the codes
    property p_gval; o_ch2_gain_code == 3'h6 |=> o_ch2_gain_value == 4'hC; endproperty
    a_gval: assert property (p_gval) else $error("gain twelve not decoded");
    property p_third;
        o_ch2_input_select == 4'h9 |=> o_third_pair_positive && o_third_pair_negative;
    endproperty
    a_third: assert property (p_third) else $error("third pair not routed");
    property p_rsv;
        o_ch2_input_select == 4'hA |=> !(o_pos_to_drive_input || o_neg_to_drive_input
            || o_third_pair_positive || o_third_pair_negative);
    endproperty
    a_rsv: assert property (p_rsv) else $error("reserved input code closed a switch");

    // ==========================================================
    // dividers: modulator period is never shorter than four clocks
    property p_modgap; o_mod_tick |=> !o_mod_tick [*3]; endproperty
    a_modgap: assert property (p_modgap) else $error("modulator ticks too close");
    property p_chop; o_chop_tick |-> o_mod_tick; endproperty
    a_chop: assert property (p_chop) else $error("chop tick off the modulator tick");
endmodule

bind chan2_drive_sense_regs chan2_drive_sense_regs_asserts u_chk (.i_clk_sys, .i_rst,
    .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata, .o_ch2_power_down, .o_ch2_gain_code,
    .o_ch2_gain_value, .o_ch2_input_select, .o_pos_to_drive_input, .o_neg_to_drive_input,
    .o_third_pair_positive, .o_third_pair_negative, .o_chop_select, .o_mod_tick, .o_chop_tick,
    .o_drive_buffer_power, .o_drive_leadoff_sense_en, .o_ch2_neg_to_drive,
    .o_ch2_pos_to_drive, .o_ch1_neg_to_drive, .o_ch1_pos_to_drive);

// ---- tb/chan2_drive_sense_regs_tb_top.sv ----
// self-checking bench of the channel-two and drive sense register bank
// assumes the bank, its package and the bound checker are compiled first
`timescale 1ns/1ps

module chan2_drive_sense_regs_tb_top;
    logic       i_clk_sys = 1'b0;
    logic       i_rst, i_wr, i_rd, i_mod_div16;
    logic [7:0] i_addr, i_wdata, o_rdata;
    logic [3:0] o_ch2_gain_value, o_ch2_input_select;
    logic [2:0] o_ch2_gain_code;
    logic [1:0] o_chop_select;
    logic       o_ch2_power_down, o_ch2_active, o_ch2_normal_input, o_ch2_inputs_shorted;
    logic       o_drive_measurement_input, o_ch2_half_supply, o_ch2_temp_sensor;
    logic       o_ch2_test_signal, o_pos_to_drive_input, o_neg_to_drive_input;
    logic       o_third_pair_positive, o_third_pair_negative, o_mod_tick, o_chop_tick;
    logic       o_drive_buffer_power, o_drive_leadoff_sense_en, o_ch2_neg_to_drive;
    logic       o_ch2_pos_to_drive, o_ch1_neg_to_drive, o_ch1_pos_to_drive;
    int         miscompares = 0;
    int         checks_done = 0;
    logic [3:0] gain_tab [0:6] = '{4'h6, 4'h1, 4'h2, 4'h3, 4'h4, 4'h8, 4'hC};

    chan2_drive_sense_regs u_dut (.i_clk_sys, .i_rst, .i_addr, .i_wdata, .i_wr, .i_rd,
        .o_rdata, .i_mod_div16, .o_ch2_power_down, .o_ch2_active, .o_ch2_gain_code,
        .o_ch2_gain_value, .o_ch2_input_select, .o_ch2_normal_input, .o_ch2_inputs_shorted,
        .o_drive_measurement_input, .o_ch2_half_supply, .o_ch2_temp_sensor, .o_ch2_test_signal,
        .o_pos_to_drive_input, .o_neg_to_drive_input, .o_third_pair_positive,
        .o_third_pair_negative, .o_chop_select, .o_mod_tick, .o_chop_tick,
        .o_drive_buffer_power, .o_drive_leadoff_sense_en, .o_ch2_neg_to_drive,
        .o_ch2_pos_to_drive, .o_ch1_neg_to_drive, .o_ch1_pos_to_drive);

    // 20 MHz system clock
    always #25 i_clk_sys = ~i_clk_sys;

    // ==========================================================
    // access and compare tasks
    task automatic chk(input logic [9:0] s, input logic [9:0] e);
        checks_done++;
        if (s !== e) begin
            miscompares++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask
    task automatic cyc();
        @(posedge i_clk_sys);
        #1;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge i_clk_sys);
        i_addr <= a; i_wdata <= d; i_wr <= 1'b1;
        @(posedge i_clk_sys);
        i_wr <= 1'b0;
    endtask
    // read data stand only in the cycle after the strobe
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge i_clk_sys);
        i_addr <= a; i_rd <= 1'b1;
        @(posedge i_clk_sys);
        i_rd <= 1'b0;
        #1;
        chk(o_rdata, e);
    endtask
    function automatic logic [9:0] mx(input int m);
        if (m < 6) return 10'h200 >> m;
        case (m)
            6: return 10'h008;
            7: return 10'h004;
            8: return 10'h00C;
            9: return 10'h003;
            default: return 10'h000;
        endcase
    endfunction
    // skip two ticks so a mid-count change settles, then time one period;
    // m picks the modulator tick instead of the chop tick
    task automatic gap(input logic [1:0] s, input logic [9:0] e, input logic m);
        logic [9:0] n;
        wr(8'h06, {s, 6'h00});
        repeat (3) begin
            n = 10'd0;
            do begin
                cyc();
                n++;
            end while (!(m ? o_mod_tick : o_chop_tick) && n < 10'd300);
        end
        chk(n, e);
    endtask
    task automatic final_report();
        $display("checks %0d mismatches %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    // ==========================================================
    // main sequence
    initial begin
        i_rst = 1'b1; i_wr = 1'b0; i_rd = 1'b0; i_mod_div16 = 1'b0;
        i_addr = 8'h00; i_wdata = 8'h00;
        repeat (12) @(posedge i_clk_sys);
        i_rst <= 1'b0;
        rd(8'h05, 8'h00);
        rd(8'h06, 8'h00);
        chk(o_ch2_gain_value, 4'h6);
        chk(o_ch2_normal_input, 1'b1);
        wr(8'h05, 8'hA5);
        rd(8'h05, 8'hA5);
        wr(8'h06, 8'h5A);
        wr(8'h07, 8'hFF);
        rd(8'h07, 8'h00);
        rd(8'h06, 8'h5A);
        $display("readback test done");
        for (int g = 0; g < 7; g++) begin
            wr(8'h05, {1'b0, g[2:0], 4'h1});
            cyc();
            chk(o_ch2_gain_value, gain_tab[g]);
        end
        for (int m = 0; m < 16; m++) begin
            wr(8'h05, {4'h0, m[3:0]});
            cyc();
            chk({o_ch2_normal_input, o_ch2_inputs_shorted, o_drive_measurement_input,
                 o_ch2_half_supply, o_ch2_temp_sensor, o_ch2_test_signal, o_pos_to_drive_input,
                 o_neg_to_drive_input, o_third_pair_positive, o_third_pair_negative},
                mx(m));
        end
        for (int i = 0; i < 8; i++) begin
            wr(8'h06, 8'h01 << i);
            cyc();
            chk({o_chop_select, o_drive_buffer_power, o_drive_leadoff_sense_en,
                 o_ch2_neg_to_drive, o_ch2_pos_to_drive, o_ch1_neg_to_drive,
                 o_ch1_pos_to_drive}, 10'h001 << i);
        end
        $display("field test done");
        wr(8'h05, 8'h81); // inputs shorted on power-down
        i_mod_div16 <= 1'b1;
        cyc();
        chk({o_ch2_power_down, o_ch2_active, o_ch2_inputs_shorted}, 10'h005);
        wr(8'h05, 8'h01);
        gap(2'h2, 10'd16, 1'b1);
        gap(2'h2, 10'd32, 1'b0);
        wr(8'h05, 8'h81); // inputs shorted on power-down
        i_mod_div16 <= 1'b0;
        wr(8'h05, 8'h01);
        gap(2'h0, 10'd4, 1'b1);
        gap(2'h0, 10'd64, 1'b0);
        gap(2'h2, 10'd8, 1'b0);
        gap(2'h3, 10'd16, 1'b0);
        gap(2'h1, 10'd64, 1'b0);
        $display("divider test done");
        final_report();
    end

    // watchdog well beyond the fewer than one thousand cycles the tests need
    initial begin
        repeat (20000) @(posedge i_clk_sys);
        miscompares++;
        final_report();
    end
endmodule
